// >>> core/imf_core.sv
// medium-rate infrared framer: apb registers, buffers, receive and transmit engines
//
// Notes on behaviour
// - hunt for flag, address follows start flags
// - two-byte hold stage keeps checksum out
// - filter: store frame on match or all-ones
// - mismatch: store nothing, wait closing flag
// - control byte stored as plain data
// - receive request when buffer holds a word
// - overrun tags last entry, stall until empty
// - closing flag: tag end, check checksum
// - back-to-back frames without re-hunting
// - seven consecutive ones mean abort
// - abort drops newest, stores oldest tagged end
// - misaligned closing flag treated as abort
// - receive disable clears receive side
// - transmit request while buffer at most half full
// - interaction pulse, then flags until data
// - shift bytes out, hardware adds flags, checksum
// - transmit request when word space free
// - underrun action chosen by software
// - completion: checksum, flag, pulse, idle flags
// - termination: abort until data, pulse, flags
// - transmit disable clears transmit side
// - insert zero after five ones
// - checksum polynomial, preset to ones
// - bytes lsb first, checksum msb first
// - zero is quarter-bit pulse, one none
`timescale 1ns/100ps
`default_nettype none
module imf_core (
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// optical line
	input  wire logic        ir_rxd,
	output logic             ir_txd,
	// service requests
	output logic             tx_service_req,
	output logic             rx_service_req
);
	import imf_pkg::*;

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = {r[14:0], 1'b0} ^ ((r[15] ^ b[i]) ? IMF_CRC_POLY : 16'h0000);
		end
		return r;
	endfunction

	// apb decode
	logic [15:0] ctrl_q;
	logic [3:0]  st_q;
	wire logic   acc      = psel & penable;
	wire logic   done     = acc & pready;
	wire logic   hit_ctrl = paddr == IMF_CTRL_OFS;
	wire logic   hit_stat = paddr == IMF_STAT_OFS;
	wire logic   hit_txd  = paddr == IMF_TXD_OFS;
	wire logic   hit_rxd  = paddr == IMF_RXD_OFS;
	wire logic   mapped   = hit_ctrl | hit_stat | hit_txd | hit_rxd;
	wire logic   tx_en    = ctrl_q[IMF_CTRL_TX_EN];
	wire logic   rx_en    = ctrl_q[IMF_CTRL_RX_EN];
	wire logic [7:0] match = ctrl_q[IMF_CTRL_MATCH +: 8];
	wire logic [7:0] bit_cyc = ctrl_q[IMF_CTRL_FAST] ? IMF_BIT_FAST : IMF_BIT_SLOW;
	wire logic [7:0] bit_last = bit_cyc - 8'h01;
	wire logic [7:0] bit_half = bit_cyc >> 1;
	wire logic [7:0] bit_qtr  = bit_cyc >> 2;

	// buffers
	logic [7:0]  tx_mem [IMF_DEPTH];
	logic [10:0] rx_mem [IMF_DEPTH];
	logic [2:0]  tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
	logic [3:0]  tx_cnt_q, rx_cnt_q;
	logic        tx_en_q, rx_en_q;
	wire logic   tx_flush = tx_en_q & ~tx_en;
	wire logic   rx_flush = rx_en_q & ~rx_en;
	wire logic   tx_push  = done & pwrite & hit_txd & (tx_cnt_q != IMF_FULL);
	wire logic   rx_pop   = done & ~pwrite & hit_rxd & (rx_cnt_q != 4'h0);
	wire logic   rx_full  = rx_cnt_q == IMF_FULL;
	wire logic [2:0] rx_last = rx_wp_q - 3'h1;
	logic        tx_pop;
	logic        rx_push, rx_tag;
	logic [10:0] rx_push_data, rx_tag_bits;
	logic [3:0]  st_set;

	// register read
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_ctrl) begin
			rd_mux[15:0] = ctrl_q;
		end else if (hit_stat) begin
			rd_mux[3:0] = st_q;
			rd_mux[IMF_ST_TXREQ] = tx_service_req;
			rd_mux[IMF_ST_RXREQ] = rx_service_req;
		end else if (hit_txd) begin
			rd_mux[3:0] = tx_cnt_q;
		end else if (hit_rxd) begin
			rd_mux[10:0] = rx_mem[rx_rp_q];
			rd_mux[IMF_RX_VALID] = rx_cnt_q != 4'h0;
		end
	end

	// apb answers after one wait cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= acc & ~pready;
			pslverr <= acc & ~pready & ~mapped;
			if (acc & ~pready) begin
				prdata <= rd_mux;
			end
		end
	end

	// control and sticky status, hardware set wins over clear
	wire logic [3:0] st_clr = (done & pwrite & hit_stat) ? pwdata[3:0] : 4'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q  <= IMF_CTRL_RST;
			st_q    <= 4'h0;
			tx_en_q <= 1'b0;
			rx_en_q <= 1'b0;
		end else begin
			if (done & pwrite & hit_ctrl) begin
				ctrl_q <= pwdata[15:0] & IMF_CTRL_MASK;
			end
			st_q    <= (st_q & ~st_clr) | st_set;
			tx_en_q <= tx_en;
			rx_en_q <= rx_en;
		end
	end

	// transmit buffer; prefill allowed while off, cleared on disable
	always_ff @(posedge pclk) begin
		if (tx_push) begin
			tx_mem[tx_wp_q] <= pwdata[7:0];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_wp_q  <= 3'h0;
			tx_rp_q  <= 3'h0;
			tx_cnt_q <= 4'h0;
		end else if (tx_flush) begin
			tx_wp_q  <= 3'h0;
			tx_rp_q  <= 3'h0;
			tx_cnt_q <= 4'h0;
		end else begin
			tx_wp_q  <= tx_wp_q + 3'(tx_push);
			tx_rp_q  <= tx_rp_q + 3'(tx_pop);
			tx_cnt_q <= tx_cnt_q + 4'(tx_push) - 4'(tx_pop);
		end
	end

	// receive buffer: push new entry or or-in tags on newest entry
	wire logic [2:0]  rx_widx = rx_push ? rx_wp_q : rx_last;
	wire logic [10:0] rx_wdat = rx_push ? rx_push_data : (rx_mem[rx_last] | rx_tag_bits);
	always_ff @(posedge pclk) begin
		if (rx_push | rx_tag) begin
			rx_mem[rx_widx] <= rx_wdat;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_wp_q  <= 3'h0;
			rx_rp_q  <= 3'h0;
			rx_cnt_q <= 4'h0;
		end else if (rx_flush) begin
			rx_wp_q  <= 3'h0;
			rx_rp_q  <= 3'h0;
			rx_cnt_q <= 4'h0;
		end else begin
			rx_wp_q  <= rx_wp_q + 3'(rx_push);
			rx_rp_q  <= rx_rp_q + 3'(rx_pop);
			rx_cnt_q <= rx_cnt_q + 4'(rx_push) - 4'(rx_pop);
		end
	end

	// service requests
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_service_req <= 1'b0;
			rx_service_req <= 1'b0;
		end else begin
			tx_service_req <= tx_en & ((IMF_FULL - tx_cnt_q) >= IMF_WORD);
			rx_service_req <= rx_en & (rx_cnt_q >= IMF_WORD);
		end
	end

	// receive bit recovery: counter restarts on each pulse leading edge
	logic [7:0] rcnt_q;
	logic       seen_q, rxd_q;
	wire logic  rx_edge = ir_rxd & ~rxd_q;
	wire logic  rx_wrap = rcnt_q == bit_last;
	wire logic  bit_ev  = rx_en & (rx_edge ? (rcnt_q >= bit_half) : rx_wrap);
	wire logic  bit_val = ~seen_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rcnt_q <= 8'h00;
			seen_q <= 1'b0;
			rxd_q  <= 1'b0;
		end else if (!rx_en) begin
			rcnt_q <= 8'h00;
			seen_q <= 1'b0;
			rxd_q  <= 1'b0;
		end else begin
			rxd_q  <= ir_rxd;
			rcnt_q <= rx_edge ? 8'h01 : (rx_wrap ? 8'h00 : rcnt_q + 8'h01);
			seen_q <= rx_edge | (seen_q & ~rx_wrap);
		end
	end

	// receive framing
	imf_rx_st_t  rx_st_q, rx_st_d;
	logic [2:0]  ones_q, ones_d, bcnt_q, bcnt_d;
	logic [7:0]  win_q, win_d, sh_q, sh_d, h0_q, h0_d, h1_q, h1_d;
	logic [1:0]  hcnt_q, hcnt_d;
	logic [15:0] rcrc_q, rcrc_d;
	logic        pushed_q, pushed_d;
	logic        abort_go;
	logic [3:0]  st_rx;
	always_comb begin
		rx_st_d = rx_st_q;
		ones_d = ones_q;
		bcnt_d = bcnt_q;
		win_d = win_q;
		sh_d = sh_q;
		h0_d = h0_q;
		h1_d = h1_q;
		hcnt_d = hcnt_q;
		rcrc_d = rcrc_q;
		pushed_d = pushed_q;
		rx_push = 1'b0;
		rx_push_data = 11'h000;
		rx_tag = 1'b0;
		rx_tag_bits = 11'h000;
		st_rx = 4'h0;
		abort_go = 1'b0;
		if (rx_st_q == IMF_RX_STALL) begin
			if (rx_cnt_q == 4'h0) begin
				rx_st_d = IMF_RX_HUNT;
			end
		end else if (bit_ev) begin
			ones_d = bit_val ? ((ones_q == IMF_ONES_MAX) ? ones_q : ones_q + 3'h1) : 3'h0;
			win_d = {bit_val, win_q[7:1]};
			if (rx_st_q == IMF_RX_HUNT) begin
				if (win_d == IMF_FLAG) begin
					rx_st_d = IMF_RX_SYNC;
				end
			end else if (bit_val && ones_q == IMF_ONES_ABORT) begin
				abort_go = rx_st_q == IMF_RX_FRAME;
				rx_st_d = IMF_RX_HUNT;
			end else if (win_d == IMF_FLAG) begin
				rx_st_d = IMF_RX_SYNC;
				if (rx_st_q == IMF_RX_FRAME) begin
					if (bcnt_q == 3'h7 && hcnt_q == 2'h2) begin
						rx_tag = pushed_q;
						rx_tag_bits[IMF_RX_EOF] = 1'b1;
						rx_tag_bits[IMF_RX_CRCERR] = rcrc_q != 16'h0000;
						st_rx[IMF_ST_CRC] = pushed_q & (rcrc_q != 16'h0000);
					end else begin
						abort_go = 1'b1;
						rx_st_d = IMF_RX_HUNT;
					end
				end
			end else if (!bit_val && ones_q == IMF_ONES_STUFF) begin
				ones_d = 3'h0;
			end else begin
				sh_d = {bit_val, sh_q[7:1]};
				bcnt_d = bcnt_q + 3'h1;
				if (bcnt_q == 3'h7 && rx_st_q != IMF_RX_SKIP) begin
					rcrc_d = crc_byte(rcrc_q, sh_d);
					h1_d = sh_d;
					h0_d = (hcnt_q == 2'h0) ? sh_d : h1_q;
					hcnt_d = (hcnt_q == 2'h2) ? hcnt_q : hcnt_q + 2'h1;
					if (rx_st_q == IMF_RX_SYNC) begin
						if (ctrl_q[IMF_CTRL_FILT] && sh_d != match && sh_d != IMF_ALLONES) begin
							rx_st_d = IMF_RX_SKIP;
						end else begin
							rx_st_d = IMF_RX_FRAME;
						end
					end else if (hcnt_q == 2'h2) begin
						if (rx_full) begin
							rx_tag = 1'b1;
							rx_tag_bits[IMF_RX_EOF] = 1'b1;
							rx_tag_bits[IMF_RX_OVR] = 1'b1;
							st_rx[IMF_ST_OVR] = 1'b1;
							rx_st_d = IMF_RX_STALL;
						end else begin
							rx_push = 1'b1;
							rx_push_data = {3'h0, h0_q};
							pushed_d = 1'b1;
						end
					end
				end
			end
			if (abort_go) begin
				rx_push = hcnt_q == 2'h2 && !rx_full;
				rx_push_data = {3'h0, h0_q};
				rx_push_data[IMF_RX_EOF] = 1'b1;
				st_rx[IMF_ST_RXABT] = 1'b1;
			end
			if (rx_st_d != rx_st_q || win_d == IMF_FLAG) begin
				if (rx_st_d == IMF_RX_SYNC || rx_st_d == IMF_RX_HUNT) begin
					bcnt_d = 3'h0;
					hcnt_d = 2'h0;
					pushed_d = 1'b0;
					rcrc_d = IMF_CRC_INIT;
				end
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_st_q  <= IMF_RX_HUNT;
			ones_q   <= 3'h0;
			bcnt_q   <= 3'h0;
			win_q    <= 8'h00;
			sh_q     <= 8'h00;
			h0_q     <= 8'h00;
			h1_q     <= 8'h00;
			hcnt_q   <= 2'h0;
			rcrc_q   <= IMF_CRC_INIT;
			pushed_q <= 1'b0;
		end else if (!rx_en) begin
			rx_st_q  <= IMF_RX_HUNT;
			ones_q   <= 3'h0;
			bcnt_q   <= 3'h0;
			win_q    <= 8'h00;
			sh_q     <= 8'h00;
			hcnt_q   <= 2'h0;
			pushed_q <= 1'b0;
		end else begin
			rx_st_q  <= rx_st_d;
			ones_q   <= ones_d;
			bcnt_q   <= bcnt_d;
			win_q    <= win_d;
			sh_q     <= sh_d;
			h0_q     <= h0_d;
			h1_q     <= h1_d;
			hcnt_q   <= hcnt_d;
			rcrc_q   <= rcrc_d;
			pushed_q <= pushed_d;
		end
	end

	// transmit engine
	imf_tx_st_t  tx_st_q, tx_st_d;
	logic [7:0]  tcnt_q;
	logic [9:0]  sip_q;
	logic [15:0] tsr_q, tsr_d, tcrc_q, tcrc_d;
	logic [4:0]  tbits_q, tbits_d;
	logic [2:0]  tones_q, tones_d;
	logic [1:0]  nflag_q, nflag_d;
	logic        tstuff_q, tstuff_d, tpend_q, tpend_d, tbit_q, tbit_d;
	wire logic   t_tick   = tcnt_q == bit_last;
	wire logic   sip_done = sip_q == IMF_SIP_CYC;
	wire logic   shifting = tx_st_q != IMF_TX_OFF && tx_st_q != IMF_TX_SIP;
	wire logic   tx_avail = tx_cnt_q != 4'h0;
	always_comb begin
		tx_st_d = tx_st_q;
		tsr_d = tsr_q;
		tbits_d = tbits_q;
		tones_d = tones_q;
		tstuff_d = tstuff_q;
		tpend_d = tpend_q;
		tbit_d = tbit_q;
		tcrc_d = tcrc_q;
		nflag_d = nflag_q;
		tx_pop = 1'b0;
		if (tx_st_q == IMF_TX_OFF) begin
			tx_st_d = IMF_TX_SIP;
		end else if (tx_st_q == IMF_TX_SIP) begin
			if (sip_done) begin
				tx_st_d = IMF_TX_FLAGS;
				tsr_d = {8'h00, IMF_FLAG};
				tbits_d = 5'h08;
				tstuff_d = 1'b0;
				nflag_d = 2'h0;
			end
		end else if (t_tick) begin
			if (tpend_q) begin
				tbit_d = 1'b0;
				tpend_d = 1'b0;
				tones_d = 3'h0;
			end else begin
				tbit_d = tsr_q[0];
				tsr_d = {1'b0, tsr_q[15:1]};
				tbits_d = tbits_q - 5'h01;
				tones_d = tsr_q[0] ? ((tones_q == IMF_ONES_MAX) ? tones_q : tones_q + 3'h1) : 3'h0;
				tpend_d = tstuff_q & tsr_q[0] & (tones_q == IMF_ONES_STUFF - 3'h1);
				if (tx_st_q == IMF_TX_DATA) begin
					tcrc_d = {tcrc_q[14:0], 1'b0} ^ ((tcrc_q[15] ^ tsr_q[0]) ? IMF_CRC_POLY : 16'h0000);
				end
				if (tbits_d == 5'h00) begin
					tstuff_d = 1'b1;
					tbits_d = 5'h08;
					case (tx_st_q)
						IMF_TX_FLAGS: begin
							if (nflag_q == 2'h2 && tx_avail) begin
								tx_st_d = IMF_TX_DATA;
								tsr_d = {8'h00, tx_mem[tx_rp_q]};
								tx_pop = 1'b1;
								tcrc_d = IMF_CRC_INIT;
							end else begin
								tsr_d = {8'h00, IMF_FLAG};
								tstuff_d = 1'b0;
								nflag_d = (nflag_q == 2'h2) ? nflag_q : nflag_q + 2'h1;
							end
						end
						IMF_TX_DATA: begin
							if (tx_avail) begin
								tsr_d = {8'h00, tx_mem[tx_rp_q]};
								tx_pop = 1'b1;
							end else if (ctrl_q[IMF_CTRL_ABTMD]) begin
								tx_st_d = IMF_TX_ABORT;
								tsr_d = {8'h00, IMF_ALLONES};
								tstuff_d = 1'b0;
							end else begin
								tx_st_d = IMF_TX_CRC;
								tsr_d = {<<{tcrc_d}};
								tbits_d = 5'h10;
							end
						end
						IMF_TX_CRC: begin
							tx_st_d = IMF_TX_CLOSE;
							tsr_d = {8'h00, IMF_FLAG};
							tstuff_d = 1'b0;
						end
						IMF_TX_ABORT: begin
							tstuff_d = 1'b0;
							tsr_d = {8'h00, IMF_ALLONES};
							if (tx_avail) begin
								tx_st_d = IMF_TX_SIP;
							end
						end
						default: begin
							tx_st_d = IMF_TX_SIP;
						end
					endcase
				end
			end
		end
	end
	wire logic tx_abt_ev = tx_st_q == IMF_TX_DATA && tx_st_d == IMF_TX_ABORT;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_st_q  <= IMF_TX_OFF;
			tcnt_q   <= 8'h00;
			sip_q    <= 10'h000;
			tsr_q    <= 16'h0000;
			tbits_q  <= 5'h00;
			tones_q  <= 3'h0;
			tstuff_q <= 1'b0;
			tpend_q  <= 1'b0;
			tbit_q   <= 1'b1;
			tcrc_q   <= IMF_CRC_INIT;
			nflag_q  <= 2'h0;
			ir_txd   <= 1'b0;
		end else if (!tx_en) begin
			tx_st_q  <= IMF_TX_OFF;
			tcnt_q   <= 8'h00;
			sip_q    <= 10'h000;
			tbits_q  <= 5'h00;
			tones_q  <= 3'h0;
			tpend_q  <= 1'b0;
			tbit_q   <= 1'b1;
			ir_txd   <= 1'b0;
		end else begin
			tx_st_q  <= tx_st_d;
			tcnt_q   <= (!shifting || t_tick) ? 8'h00 : tcnt_q + 8'h01;
			sip_q    <= (tx_st_q == IMF_TX_SIP && !sip_done) ? sip_q + 10'h001 : 10'h000;
			tsr_q    <= tsr_d;
			tbits_q  <= tbits_d;
			tones_q  <= tones_d;
			tstuff_q <= tstuff_d;
			tpend_q  <= tpend_d;
			tbit_q   <= tbit_d;
			tcrc_q   <= tcrc_d;
			nflag_q  <= nflag_d;
			ir_txd   <= (tx_st_q == IMF_TX_SIP) ? (sip_q < IMF_SIP_HIGH_CYC)
				: (shifting & ~tbit_q & (tcnt_q < bit_qtr));
		end
	end
	assign st_set = st_rx | ({3'h0, tx_abt_ev} << IMF_ST_TXABT);
endmodule
`default_nettype wire

// >>> include/imf_pkg.sv
// constants and types for the medium-rate infrared framer
package imf_pkg;
	// register byte offsets
	localparam logic [7:0] IMF_CTRL_OFS = 8'h00;
	localparam logic [7:0] IMF_STAT_OFS = 8'h04;
	localparam logic [7:0] IMF_TXD_OFS  = 8'h08;
	localparam logic [7:0] IMF_RXD_OFS  = 8'h0C;
	// control fields
	localparam int IMF_CTRL_TX_EN  = 0;
	localparam int IMF_CTRL_RX_EN  = 1;
	localparam int IMF_CTRL_FILT   = 2;
	localparam int IMF_CTRL_ABTMD  = 3;
	localparam int IMF_CTRL_FAST   = 4;
	localparam int IMF_CTRL_MATCH  = 8;
	localparam logic [15:0] IMF_CTRL_RST  = 16'h0000;
	localparam logic [15:0] IMF_CTRL_MASK = 16'hFF1F;
	// status fields, sticky ones write-one-to-clear
	localparam int IMF_ST_CRC    = 0;
	localparam int IMF_ST_RXABT  = 1;
	localparam int IMF_ST_TXABT  = 2;
	localparam int IMF_ST_OVR    = 3;
	localparam int IMF_ST_TXREQ  = 8;
	localparam int IMF_ST_RXREQ  = 9;
	// receive entry fields
	localparam int IMF_RX_EOF    = 8;
	localparam int IMF_RX_CRCERR = 9;
	localparam int IMF_RX_OVR    = 10;
	localparam int IMF_RX_VALID  = 11;
	// buffers
	localparam int          IMF_DEPTH   = 8;
	localparam logic [3:0]  IMF_FULL    = 4'h8;
	localparam logic [3:0]  IMF_WORD    = 4'h4;
	// framing
	localparam logic [7:0]  IMF_FLAG     = 8'h7E;
	localparam logic [7:0]  IMF_ALLONES  = 8'hFF;
	localparam logic [15:0] IMF_CRC_INIT = 16'hFFFF;
	localparam logic [15:0] IMF_CRC_POLY = 16'h1021;
	localparam logic [2:0]  IMF_ONES_STUFF = 3'h5;
	localparam logic [2:0]  IMF_ONES_ABORT = 3'h6;
	localparam logic [2:0]  IMF_ONES_MAX   = 3'h7;
	// timing
	localparam int IMF_CLK_HZ    = 125_000_000;
	localparam int IMF_RATE_FAST = 1_152_000;
	localparam int IMF_RATE_SLOW = 576_000;
	localparam logic [7:0] IMF_BIT_FAST = 8'(IMF_CLK_HZ / IMF_RATE_FAST);
	localparam logic [7:0] IMF_BIT_SLOW = 8'(IMF_CLK_HZ / IMF_RATE_SLOW);
	localparam int IMF_CLK_NS     = 8;
	localparam int IMF_SIP_HIGH_NS = 1600;
	localparam int IMF_SIP_LOW_NS  = 5500;
	localparam logic [9:0] IMF_SIP_HIGH_CYC = 10'((IMF_SIP_HIGH_NS + IMF_CLK_NS - 1) / IMF_CLK_NS);
	localparam logic [9:0] IMF_SIP_CYC = 10'((IMF_SIP_HIGH_NS + IMF_SIP_LOW_NS + IMF_CLK_NS - 1) / IMF_CLK_NS);
	typedef enum logic [2:0] {IMF_RX_HUNT, IMF_RX_SYNC, IMF_RX_FRAME, IMF_RX_SKIP, IMF_RX_STALL} imf_rx_st_t;
	typedef enum logic [2:0] {IMF_TX_OFF, IMF_TX_SIP, IMF_TX_FLAGS, IMF_TX_DATA, IMF_TX_CRC, IMF_TX_CLOSE,
		IMF_TX_ABORT} imf_tx_st_t;
endpackage

// >>> verif/imf_sva.sv
// port assertions for the infrared framer
`timescale 1ns/100ps
`default_nettype none
module imf_sva (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	// line and requests
	input wire logic ir_txd,
	input wire logic tx_service_req,
	input wire logic rx_service_req
);
	logic [9:0] hi_q;
	logic [9:0] lo_q;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// run lengths of light and dark on the tx line
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_q <= 10'h000;
			lo_q <= 10'h3FF;
		end else begin
			hi_q <= ir_txd ? hi_q + 10'h001 : 10'h000;
			lo_q <= ir_txd ? 10'h000 : (lo_q == 10'h3FF ? lo_q : lo_q + 10'h001);
		end
	end
	sequence s_setup;
		psel && !penable ##1 psel && penable;
	endsequence
	a_ready_wait: assert property (s_setup |-> !pready ##1 pready)
		else $error("pready not after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_ready_cause: assert property (pready |-> psel && penable && $past(psel && penable))
		else $error("pready without access");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_pulse_width: assert property ($fell(ir_txd) |-> hi_q == 10'h01B || hi_q == 10'h036 || hi_q == 10'h0C8)
		else $error("tx pulse width wrong");
	a_pulse_gap: assert property ($rose(ir_txd) |-> lo_q >= 10'h051)
		else $error("tx pulses too close");
	a_txreq_fall: assert property ($fell(tx_service_req) |-> $past(pready && pwrite) || $past(pready && pwrite, 2))
		else $error("tx request dropped without write");
	a_rxreq_fall: assert property ($fell(rx_service_req) |-> $past(pready) || $past(pready, 2))
		else $error("rx request dropped without access");
endmodule
bind imf_core imf_sva imf_sva_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pready(pready), .pslverr(pslverr), .ir_txd(ir_txd), .tx_service_req(tx_service_req),
	.rx_service_req(rx_service_req));
`default_nettype wire

// >>> verif/imf_xcvr.sv
// transceiver model: drives rx line, turns tx pulses into bits
`timescale 1ns/100ps
`default_nettype none
module imf_xcvr #(parameter int P = 108) (
	// line
	input  wire logic pclk,
	input  wire logic ir_txd,
	output var logic  ir_rxd
);
	logic tq[$];
	logic prev;
	int   cnt;
	initial begin
		ir_rxd = 1'b0;
		prev = 1'b0;
		cnt = 0;
	end
	// zero is a quarter-bit pulse, one stays dark
	task tx_bit(input logic b);
		ir_rxd <= !b;
		repeat (P / 4) @(posedge pclk);
		ir_rxd <= 1'b0;
		repeat (P - P / 4) @(posedge pclk);
	endtask
	// each pulse closes a run of ones and carries a zero
	always @(posedge pclk) begin
		prev <= ir_txd;
		cnt <= cnt + 1;
		if (ir_txd && !prev) begin
			repeat ((cnt + P / 2) / P - 1) tq.push_back(1'b1);
			tq.push_back(1'b0);
			cnt <= 1;
		end
	end
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench for the infrared framer
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import imf_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ir_rxd;
	logic        ir_txd;
	logic        tx_service_req;
	logic        rx_service_req;
	int          bad_count = 0;
	int          tests_run = 0;
	int          seed = 37384;
	int          cyc = 0;
	int          ones;
	logic [31:0] rd;
	logic        er;
	logic [7:0]  match;
	logic [7:0]  txd[$];
	logic        bq[$];
	logic [11:0] exq[$];

	imf_core imf_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ir_rxd(ir_rxd), .ir_txd(ir_txd), .tx_service_req(tx_service_req), .rx_service_req(rx_service_req));
	imf_xcvr imf_xcvr_i (.pclk(pclk), .ir_txd(ir_txd), .ir_rxd(ir_rxd));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 100000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	task tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
		return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? IMF_CRC_POLY : 16'h0000);
	endfunction
	task flag();
		ones = 0;
		for (int j = 0; j < 8; j++) bq.push_back(IMF_FLAG[j]);
	endtask
	task put(input logic b, input bit s);
		bq.push_back(b);
		if (s) begin
			ones = b ? ones + 1 : 0;
			if (ones == 5) begin
				bq.push_back(1'b0);
				ones = 0;
			end
		end
	endtask
	// m: 0 good, 1 bad checksum, 2 not for us, 3 aborted; lengths over 8 overrun the buffer
	task automatic frame(input logic [7:0] a, input int n, input int m);
		logic [7:0]  d[$];
		logic [15:0] c;
		logic [11:0] e;
		c = IMF_CRC_INIT;
		d.push_back(a);
		repeat (n - 1) d.push_back(8'($random(seed)));
		flag();
		flag();
		foreach (d[i]) begin
			for (int j = 0; j < 8; j++) begin
				put(d[i][j], 1);
				c = crc_step(c, d[i][j]);
			end
			e = {4'h8, d[i]};
			if (i == 7 && n > 8) e = e | 12'h500;
			else if (i == n - 1 || (m == 3 && i == n - 2)) e = e | (m == 1 ? 12'h300 : 12'h100);
			if (m != 2 && i < 8 && !(m == 3 && i == n - 1)) exq.push_back(e);
		end
		if (m == 3) repeat (8) put(1'b1, 0);
		else begin
			if (m == 1) c = ~c;
			for (int j = 15; j >= 0; j--) put(c[j], 1);
			flag();
		end
	endtask
	task send();
		foreach (bq[i]) imf_xcvr_i.tx_bit(bq[i]);
		bq.delete();
		repeat (600) @(posedge pclk);
	endtask
	task drain();
		logic [11:0] e;
		do begin
			apb(1'b0, IMF_RXD_OFS, 32'h0);
			e = exq.size() ? exq.pop_front() : 12'h000;
			if (e != 12'h000) chk(rd, {20'h0, e});
			else chk(rd[IMF_RX_VALID], 32'h0);
		end while (e != 12'h000);
	endtask
	task txdec();
		logic [7:0]  w;
		logic [15:0] rc;
		logic [15:0] cc;
		logic        f[$];
		logic        b;
		int          on;
		bit          inf;
		w = 8'h00;
		on = 0;
		inf = 0;
		cc = IMF_CRC_INIT;
		while (imf_xcvr_i.tq.size() > 0) begin
			b = imf_xcvr_i.tq.pop_front();
			w = {w[6:0], b};
			if (w == IMF_FLAG) begin
				if (f.size() > 7) break;
				inf = 1;
				f.delete();
				on = 0;
			end else if (inf && on == 5 && !b) on = 0;
			else if (inf) begin
				f.push_back(b);
				on = b ? on + 1 : 0;
			end
		end
		chk(f.size(), 8 * txd.size() + 23);
		if (f.size() == 8 * txd.size() + 23) begin
			foreach (txd[i]) for (int j = 0; j < 8; j++) begin
				chk(f[8 * i + j], txd[i][j]);
				cc = crc_step(cc, txd[i][j]);
			end
			for (int j = 0; j < 16; j++) rc = {rc[14:0], f[8 * txd.size() + j]};
			chk(rc, cc);
		end
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		match = 8'($random(seed)) & 8'h7E;
		apb(1'b0, IMF_CTRL_OFS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, IMF_STAT_OFS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk(er, 32'h1);
		apb(1'b1, IMF_CTRL_OFS, {16'h0, match, 8'h16});
		apb(1'b0, IMF_CTRL_OFS, 32'h0);
		chk(rd, {16'h0, match, 8'h16});
		$display("test registers done");
		for (int k = 0; k < 6; k++) begin
			case (k)
				0: begin
					frame(match, 3, 0);
					frame(match, 3, 1);
				end
				1: frame(match ^ 8'h80, 2, 2);
				2: frame(IMF_ALLONES, 2, 0);
				3: frame(match, 4, 3);
				4: frame(match, 11, 0);
				default: frame(match, 2, 0);
			endcase
			send();
			if (k == 3) begin
				apb(1'b0, IMF_STAT_OFS, 32'h0);
				chk(rd[IMF_ST_RXABT], 32'h1);
				apb(1'b1, IMF_STAT_OFS, 32'h0000000F);
			end
			if (k == 4) chk(rx_service_req, 32'h1);
			if (k == 5) begin
				apb(1'b1, IMF_CTRL_OFS, {16'h0, match, 8'h14});
				apb(1'b1, IMF_CTRL_OFS, {16'h0, match, 8'h16});
				exq.delete();
			end
			drain();
			$display("test rx %0d done", k);
		end
		apb(1'b1, IMF_CTRL_OFS, 32'h00000010);
		repeat (3) begin
			txd.push_back(8'($random(seed)));
			apb(1'b1, IMF_TXD_OFS, {24'h0, txd[$]});
		end
		chk(tx_service_req, 32'h0);
		apb(1'b1, IMF_CTRL_OFS, 32'h00000011);
		repeat (2) @(posedge pclk);
		chk(tx_service_req, 32'h1);
		repeat (12000) @(posedge pclk);
		txdec();
		$display("test tx done");
		apb(1'b1, IMF_CTRL_OFS, 32'h00000019);
		repeat (2) apb(1'b1, IMF_TXD_OFS, 32'h000000A5);
		repeat (8000) @(posedge pclk);
		apb(1'b0, IMF_STAT_OFS, 32'h0);
		chk(rd[IMF_ST_TXABT], 32'h1);
		repeat (3) apb(1'b1, IMF_TXD_OFS, 32'h000000C3);
		repeat (300) @(posedge pclk);
		// disable only just after a pulse, so no pulse is cut short
		while (ir_txd !== 1'b1) @(posedge pclk);
		while (ir_txd === 1'b1) @(posedge pclk);
		apb(1'b1, IMF_CTRL_OFS, 32'h00000010);
		apb(1'b0, IMF_TXD_OFS, 32'h0);
		chk(rd, 32'h0);
		$display("test tx abort done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
